// *** rtl/mtcu_channel_unit.sv ***
// Purpose: four capture/compare channels, outputs with dead time, break, master trigger
// Assumes: counter value, direction and update event come from logic on ref_clk
// Notes:   registers on Avalon-MM; every access answers after one wait cycle
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module mtcu_channel_unit (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [7:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic [mtcu_pkg::CNT_W-1:0]    counterValue,
  input  wire logic                         countDown,
  input  wire logic                         updateEvent1,
  input  wire logic [mtcu_pkg::NUM_CH-1:0]   channelPin,
  input  wire logic                         breakInput,
  input  wire logic                         clockFailure,
  output logic      [mtcu_pkg::NUM_CH-1:0]   primaryOutput,
  output logic      [mtcu_pkg::NUM_CH-1:0]   primaryOutputEn_n,
  output logic      [mtcu_pkg::NUM_COMP-1:0] complementaryOutput,
  output logic      [mtcu_pkg::NUM_COMP-1:0] complementaryOutputEn_n,
  output logic                              masterTriggerOutput,
  output logic                              breakIrq
);

  typedef struct packed {
    logic                                               waitReq;
    logic [31:0]                                        rdata;
    logic [mtcu_pkg::NUM_CH-1:0]                        pinS1;
    logic [mtcu_pkg::NUM_CH-1:0]                        pinS2;
    logic                                               brkS1;
    logic                                               brkS2;
    logic                                               cfS1;
    logic                                               cfS2;
    logic [2:0]                                         masterOutputSelect;
    logic                                               ch0XorSelect;
    logic                                               breakEnable;
    logic                                               breakPolarity;
    logic [2:0]                                         breakFilterSelect;
    logic                                               mainOutputEnable;
    logic                                               breakInterruptEnable;
    logic                                               breakFlag;
    logic                                               swBreak;
    logic [mtcu_pkg::NUM_CH-1:0]                        ccFlag;
    logic [mtcu_pkg::NUM_CH-1:0]                        ocFlag;
    logic [mtcu_pkg::NUM_CH-1:0][mtcu_pkg::CFG_W-1:0]   chCfg;
    logic [mtcu_pkg::NUM_CH-1:0][mtcu_pkg::CNT_W-1:0]   ccPreload;
    logic [mtcu_pkg::NUM_CH-1:0][mtcu_pkg::CNT_W-1:0]   ccShadow;
    logic [mtcu_pkg::NUM_CH-1:0]                        capPending;
    logic [mtcu_pkg::NUM_CH-1:0]                        filtPrev;
    logic [mtcu_pkg::NUM_CH-1:0][2:0]                   pscCnt;
    logic [mtcu_pkg::NUM_CH-1:0]                        matchPrev;
    logic [mtcu_pkg::NUM_CH-1:0]                        outRef;
    logic [mtcu_pkg::DT_W-1:0]                          deadTime;
    logic [mtcu_pkg::NUM_CH-1:0]                        priOut;
    logic [mtcu_pkg::NUM_CH-1:0]                        priOe_n;
    logic [mtcu_pkg::NUM_COMP-1:0]                      compOut;
    logic [mtcu_pkg::NUM_COMP-1:0]                      compOe_n;
    logic                                               master_trigger_output;
    logic                                               irq;
  } mtcu_state_t;

  mtcu_state_t                    q;
  mtcu_state_t                    next_q;
  logic [mtcu_pkg::NUM_CH:0]      fltIn;
  logic [mtcu_pkg::NUM_CH:0]      filtered;
  logic [mtcu_pkg::NUM_CH-1:0]    priSel;
  logic [mtcu_pkg::NUM_COMP-1:0]  compSel;
  logic [mtcu_pkg::NUM_COMP-1:0]  insertDt;

  ////////////////////////////////////////////////////////////////////////////////
  // input filters: four channels plus break

  assign fltIn[0] = q.ch0XorSelect ? (q.pinS2[0] ^ q.pinS2[1] ^ q.pinS2[2]) : q.pinS2[0];
  assign fltIn[1] = q.pinS2[1];
  assign fltIn[2] = q.pinS2[2];
  assign fltIn[3] = q.pinS2[3];
  // polarity applies after the filter, so enable and polarity in one write never
  // sees a stale filtered level from the old polarity
  assign fltIn[mtcu_pkg::NUM_CH] = q.brkS2;

  for (genvar g = 0; g <= mtcu_pkg::NUM_CH; g++) begin : gFilt
    logic [2:0] sel;
    if (g == mtcu_pkg::NUM_CH) begin : gBrk
      assign sel = q.breakFilterSelect;
    end else begin : gCh
      assign sel = q.chCfg[g][mtcu_pkg::F_FLT +: 3];
    end
    mtcu_filter uFilt (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (fltIn[g]),
      .len     (mtcu_pkg::mtcu_flt_len(sel)),
      .dout    (filtered[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dead time on channels 0 to 2

  for (genvar g = 0; g < mtcu_pkg::NUM_COMP; g++) begin : gDead
    assign insertDt[g] = q.chCfg[g][mtcu_pkg::F_PE] & q.chCfg[g][mtcu_pkg::F_CE];
    mtcu_deadtime uDead (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .refWave       (q.outRef[g]),
      .deadTime      (q.deadTime),
      .insert        (insertDt[g]),
      .primary       (priSel[g]),
      .complementary (compSel[g])
    );
  end
  assign priSel[3] = q.outRef[3];

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [31:0]                 rd;
    logic [31:0]                 wmask;
    logic [31:0]                 wv;
    logic                        wrEn;
    logic [mtcu_pkg::NUM_CH-1:0] ccClr;
    logic [mtcu_pkg::NUM_CH-1:0] ocClr;
    logic [mtcu_pkg::NUM_CH-1:0] capSet;
    logic [mtcu_pkg::NUM_CH-1:0] ovSet;
    logic                        brkClr;
    logic                        brkEv;
    logic [1:0]                  ccs;
    logic                        edgeEv;
    logic                        cur;
    logic                        prev;
    logic                        match;
    logic                        below;
    logic [2:0]                  pscTop;
    rd     = '0;
    wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wv     = '0;
    wrEn   = avs_write & ~q.waitReq;
    ccClr  = '0;
    ocClr  = '0;
    capSet = '0;
    ovSet  = '0;
    brkClr = 1'b0;
    brkEv  = 1'b0;
    ccs    = '0;
    edgeEv = 1'b0;
    cur    = 1'b0;
    prev   = 1'b0;
    match  = 1'b0;
    below  = 1'b0;
    pscTop = '0;
    next_q = q;

    // pins from outside pass two flops before use
    next_q.pinS1 = channelPin;
    next_q.pinS2 = q.pinS1;
    next_q.brkS1 = breakInput;
    next_q.brkS2 = q.brkS1;
    next_q.cfS1  = clockFailure;
    next_q.cfS2  = q.cfS1;

    // bus: one wait cycle, then the access completes
    next_q.waitReq = ~((avs_read | avs_write) & q.waitReq);
    next_q.swBreak = 1'b0;

    unique case (avs_address)
      mtcu_pkg::OFS_CTRL: begin
        rd[mtcu_pkg::C_MMS +: 3] = q.masterOutputSelect;
        rd[mtcu_pkg::C_XOR]      = q.ch0XorSelect;
        rd[mtcu_pkg::C_BKE]      = q.breakEnable;
        rd[mtcu_pkg::C_BKP]      = q.breakPolarity;
        rd[mtcu_pkg::C_BKF +: 3] = q.breakFilterSelect;
        rd[mtcu_pkg::C_MOE]      = q.mainOutputEnable;
        rd[mtcu_pkg::C_BIE]      = q.breakInterruptEnable;
      end
      mtcu_pkg::OFS_STAT: begin
        rd[mtcu_pkg::S_CC +: 4] = q.ccFlag;
        rd[mtcu_pkg::S_OC +: 4] = q.ocFlag;
        rd[mtcu_pkg::S_BRK]     = q.breakFlag;
      end
      mtcu_pkg::OFS_DT: begin
        rd[mtcu_pkg::DT_W-1:0] = q.deadTime;
      end
      default: begin
        for (int i = 0; i < mtcu_pkg::NUM_CH; i++) begin
          if (avs_address == 8'(mtcu_pkg::OFS_CFG0 + mtcu_pkg::OFS_STEP * i)) begin
            rd[mtcu_pkg::CFG_W-1:0] = q.chCfg[i];
          end
          if (avs_address == 8'(mtcu_pkg::OFS_CCR0 + mtcu_pkg::OFS_STEP * i)) begin
            rd[mtcu_pkg::CNT_W-1:0] = q.ccPreload[i];
          end
        end
      end
    endcase
    wv = (rd & ~wmask) | (avs_writedata & wmask);
    if (avs_read & q.waitReq) begin
      next_q.rdata = rd;
    end

    if (wrEn) begin
      unique case (avs_address)
        mtcu_pkg::OFS_CTRL: begin
          next_q.masterOutputSelect   = wv[mtcu_pkg::C_MMS +: 3];
          next_q.ch0XorSelect         = wv[mtcu_pkg::C_XOR];
          next_q.breakEnable          = wv[mtcu_pkg::C_BKE];
          next_q.breakPolarity        = wv[mtcu_pkg::C_BKP];
          next_q.breakFilterSelect    = wv[mtcu_pkg::C_BKF +: 3];
          next_q.mainOutputEnable     = wv[mtcu_pkg::C_MOE];
          next_q.breakInterruptEnable = wv[mtcu_pkg::C_BIE];
          next_q.swBreak              = wv[mtcu_pkg::C_SOFTWARE_BREAK_GENERATE];
        end
        mtcu_pkg::OFS_STAT: begin
          ccClr  = avs_writedata[mtcu_pkg::S_CC +: 4] & wmask[mtcu_pkg::S_CC +: 4];
          ocClr  = avs_writedata[mtcu_pkg::S_OC +: 4] & wmask[mtcu_pkg::S_OC +: 4];
          brkClr = avs_writedata[mtcu_pkg::S_BRK] & wmask[mtcu_pkg::S_BRK];
        end
        mtcu_pkg::OFS_DT: begin
          next_q.deadTime = wv[mtcu_pkg::DT_W-1:0];
        end
        default: begin
          for (int i = 0; i < mtcu_pkg::NUM_CH; i++) begin
            if (avs_address == 8'(mtcu_pkg::OFS_CFG0 + mtcu_pkg::OFS_STEP * i)) begin
              next_q.chCfg[i] = wv[mtcu_pkg::CFG_W-1:0];
            end
            if (avs_address == 8'(mtcu_pkg::OFS_CCR0 + mtcu_pkg::OFS_STEP * i)) begin
              next_q.ccPreload[i] = wv[mtcu_pkg::CNT_W-1:0];
            end
          end
        end
      endcase
    end

    // channel capture and compare; hardware transfer wins over a bus write
    next_q.filtPrev = filtered[mtcu_pkg::NUM_CH-1:0];
    for (int i = 0; i < mtcu_pkg::NUM_CH; i++) begin
      ccs    = q.chCfg[i][mtcu_pkg::F_CCS +: 2];
      cur    = (ccs == mtcu_pkg::CCS_NEIGH) ? filtered[i ^ 1] : filtered[i];
      prev   = (ccs == mtcu_pkg::CCS_NEIGH) ? q.filtPrev[i ^ 1] : q.filtPrev[i];
      edgeEv = q.chCfg[i][mtcu_pkg::F_POL] ? (prev & ~cur) : (~prev & cur);
      pscTop = 3'((4'h1 << q.chCfg[i][mtcu_pkg::F_PSC +: 2]) - 4'h1);
      next_q.capPending[i] = 1'b0;
      if ((ccs != mtcu_pkg::CCS_OUT) && edgeEv) begin
        if (q.pscCnt[i] >= pscTop) begin
          next_q.pscCnt[i]     = '0;
          next_q.ccShadow[i]   = counterValue;
          next_q.capPending[i] = 1'b1;
        end else begin
          next_q.pscCnt[i] = q.pscCnt[i] + 3'h1;
        end
      end
      if (q.capPending[i]) begin
        next_q.ccPreload[i] = q.ccShadow[i];
        capSet[i]           = 1'b1;
        ovSet[i]            = q.ccFlag[i] & ~ccClr[i];
      end
      if ((ccs == mtcu_pkg::CCS_OUT) && updateEvent1) begin
        next_q.ccShadow[i] = q.ccPreload[i];
      end
      match               = (counterValue == q.ccShadow[i]);
      below               = (counterValue < q.ccShadow[i]);
      next_q.matchPrev[i] = match;
      if ((ccs == mtcu_pkg::CCS_OUT) && match && !q.matchPrev[i]) begin
        capSet[i] = 1'b1;
      end
      if (ccs != mtcu_pkg::CCS_OUT) begin
        next_q.outRef[i] = 1'b0;
      end else begin
        unique case (mtcu_pkg::mtcu_om_t'(q.chCfg[i][mtcu_pkg::F_OM +: 3]))
          mtcu_pkg::OM_HOLD:     next_q.outRef[i] = q.outRef[i];
          mtcu_pkg::OM_CLEAR:    next_q.outRef[i] = match ? 1'b0 : q.outRef[i];
          mtcu_pkg::OM_SET:      next_q.outRef[i] = match ? 1'b1 : q.outRef[i];
          mtcu_pkg::OM_TOGGLE:   next_q.outRef[i] = q.outRef[i] ^ (match & ~q.matchPrev[i]);
          mtcu_pkg::OM_FORCE_LO: next_q.outRef[i] = 1'b0;
          mtcu_pkg::OM_FORCE_HI: next_q.outRef[i] = 1'b1;
          mtcu_pkg::OM_PWM1:     next_q.outRef[i] = countDown ? (below | match) : below;
          mtcu_pkg::OM_PWM2:     next_q.outRef[i] = countDown ? ~(below | match) : ~below;
        endcase
      end
    end
    // set wins over a clear in the same cycle
    next_q.ccFlag = (q.ccFlag & ~ccClr) | capSet;
    next_q.ocFlag = (q.ocFlag & ~ocClr) | ovSet;

    // break; software break bypasses the enable
    // polarity 1 means active-high pin; sense is active high after the xnor
    brkEv = (q.breakEnable & ((filtered[mtcu_pkg::NUM_CH] ~^ q.breakPolarity) | q.cfS2))
            | q.swBreak;
    if (brkEv) begin
      next_q.mainOutputEnable = 1'b0;
    end
    next_q.breakFlag = (q.breakFlag & ~brkClr) | brkEv;
    next_q.irq       = next_q.breakFlag & next_q.breakInterruptEnable;

    // output pins; oe low while driving; break drives enabled pins inactive
    for (int i = 0; i < mtcu_pkg::NUM_CH; i++) begin
      next_q.priOe_n[i] = ~q.chCfg[i][mtcu_pkg::F_PE];
      next_q.priOut[i]  = q.mainOutputEnable & priSel[i];
    end
    for (int i = 0; i < mtcu_pkg::NUM_COMP; i++) begin
      next_q.compOe_n[i] = ~q.chCfg[i][mtcu_pkg::F_CE];
      next_q.compOut[i]  = q.mainOutputEnable & compSel[i];
    end

    unique case (q.masterOutputSelect)
      mtcu_pkg::MMS_UPDATE: next_q.master_trigger_output = updateEvent1;
      mtcu_pkg::MMS_CAPT:   next_q.master_trigger_output = |capSet;
      mtcu_pkg::MMS_REF0:   next_q.master_trigger_output = q.outRef[0];
      mtcu_pkg::MMS_REF1:   next_q.master_trigger_output = q.outRef[1];
      mtcu_pkg::MMS_REF2:   next_q.master_trigger_output = q.outRef[2];
      mtcu_pkg::MMS_REF3:   next_q.master_trigger_output = q.outRef[3];
      default:              next_q.master_trigger_output = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q          <= '0;
      q.waitReq  <= 1'b1;
      q.priOe_n  <= '1;
      q.compOe_n <= '1;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata            = q.rdata;
  assign avs_waitrequest         = q.waitReq;
  assign primaryOutput           = q.priOut;
  assign primaryOutputEn_n       = q.priOe_n;
  assign complementaryOutput     = q.compOut;
  assign complementaryOutputEn_n = q.compOe_n;
  assign masterTriggerOutput     = q.master_trigger_output;
  assign breakIrq                = q.irq;

endmodule

// *** rtl/mtcu_pkg.sv ***
// Purpose: shared constants and types of the motor timer channel unit
// Assumes: byte addresses on an 8-bit Avalon-MM address, one 32-bit word per register
// Notes:   field positions are bit offsets inside each register word
package mtcu_pkg;

  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned NUM_COMP = 3;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned DT_W     = 8;
  localparam int unsigned FLT_W    = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CFG0 = 8'h08;
  localparam logic [7:0] OFS_CCR0 = 8'h18;
  localparam logic [7:0] OFS_DT   = 8'h28;
  localparam logic [7:0] OFS_STEP = 8'h04;

  ////////////////////////////////////////////////////////////////////////////////
  // control word fields
  localparam int unsigned C_MMS  = 0;
  localparam int unsigned C_XOR  = 3;
  localparam int unsigned C_BKE  = 4;
  localparam int unsigned C_BKP  = 5;
  localparam int unsigned C_BKF  = 6;
  localparam int unsigned C_MOE  = 9;
  localparam int unsigned C_BIE  = 10;
  localparam int unsigned C_SOFTWARE_BREAK_GENERATE = 11;

  // status word fields, write one to clear
  localparam int unsigned S_CC  = 0;
  localparam int unsigned S_OC  = 4;
  localparam int unsigned S_BRK = 8;

  // channel configuration fields
  localparam int unsigned F_CCS = 0;
  localparam int unsigned F_POL = 2;
  localparam int unsigned F_FLT = 3;
  localparam int unsigned F_PSC = 6;
  localparam int unsigned F_OM  = 8;
  localparam int unsigned F_PE  = 11;
  localparam int unsigned F_CE  = 12;
  localparam int unsigned CFG_W = 13;

  ////////////////////////////////////////////////////////////////////////////////
  // codes and reset values
  localparam logic [1:0] CCS_OUT   = 2'h0;
  localparam logic [1:0] CCS_OWN   = 2'h1;
  localparam logic [1:0] CCS_NEIGH = 2'h2;

  localparam logic [2:0] MMS_UPDATE = 3'h0;
  localparam logic [2:0] MMS_CAPT   = 3'h1;
  localparam logic [2:0] MMS_REF0   = 3'h4;
  localparam logic [2:0] MMS_REF1   = 3'h5;
  localparam logic [2:0] MMS_REF2   = 3'h6;
  localparam logic [2:0] MMS_REF3   = 3'h7;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    OM_HOLD, OM_CLEAR, OM_SET, OM_TOGGLE, OM_FORCE_LO, OM_FORCE_HI, OM_PWM1, OM_PWM2
  } mtcu_om_t;

  // filter select code to required sample count
  function automatic logic [FLT_W-1:0] mtcu_flt_len(input logic [2:0] sel);
    case (sel)
      3'h0:    mtcu_flt_len = 4'h0;
      3'h1:    mtcu_flt_len = 4'h2;
      3'h2:    mtcu_flt_len = 4'h4;
      3'h3:    mtcu_flt_len = 4'h5;
      3'h4:    mtcu_flt_len = 4'h6;
      default: mtcu_flt_len = 4'h8;
    endcase
  endfunction

endpackage

// *** rtl/mtcu_filter.sv ***
// Purpose: event-counter glitch filter for one synchronised input
// Assumes: din already passed a two-stage synchroniser
// Notes:   len of zero passes the input with one cycle of latency
`timescale 1ns/100ps
module mtcu_filter (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      din,
  input  wire logic [mtcu_pkg::FLT_W-1:0] len,
  output logic                           dout
);

  typedef struct packed {
    logic                      level;
    logic [mtcu_pkg::FLT_W-1:0] cnt;
  } mtcu_flt_t;

  mtcu_flt_t q;
  mtcu_flt_t next_q;

  // a sample that agrees with the output restarts the run
  always_comb begin
    next_q = q;
    if (din == q.level) begin
      next_q.cnt = '0;
    end else if ((q.cnt + 4'h1) >= len) begin
      next_q.level = din;
      next_q.cnt   = '0;
    end else begin
      next_q.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign dout = q.level;

endmodule

// *** rtl/mtcu_deadtime.sv ***
// Purpose: dead-time insertion for one complementary channel pair
// Assumes: refWave is a registered reference waveform on ref_clk
// Notes:   each ref edge reloads the delay, so a pulse shorter than dt never appears
`timescale 1ns/100ps
module mtcu_deadtime (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     refWave,
  input  wire logic [mtcu_pkg::DT_W-1:0] deadTime,
  input  wire logic                     insert,
  output logic                          primary,
  output logic                          complementary
);

  typedef struct packed {
    logic                     prevRef;
    logic [mtcu_pkg::DT_W-1:0] cnt;
    logic                     primary;
    logic                     complementary;
  } mtcu_dt_t;

  mtcu_dt_t q;
  mtcu_dt_t next_q;

  always_comb begin
    next_q         = q;
    next_q.prevRef = refWave;
    if (refWave != q.prevRef) begin
      next_q.cnt = deadTime;
    end else if (q.cnt != '0) begin
      next_q.cnt = q.cnt - 8'h01;
    end
    if (insert) begin
      next_q.primary       = refWave & (next_q.cnt == '0);
      next_q.complementary = ~refWave & (next_q.cnt == '0);
    end else begin
      next_q.primary       = refWave;
      next_q.complementary = ~refWave;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign primary       = q.primary;
  assign complementary = q.complementary;

endmodule

// *** verif/mtcu_pins_model.sv ***
// Purpose: far-side pins: channel inputs, break pin, clock failure
// Assumes: bench requests levels on ref_clk
// Notes:   slow mode adds a cycle of lag
`timescale 1ns/100ps
module mtcu_pins_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic [5:0] req,
  output logic      [3:0] channelPin,
  output logic            breakInput,
  output logic            clockFailure
);
  logic [5:0] d1 = '0;
  logic [5:0] d2 = '0;
  always @(posedge ref_clk) begin
    d1 <= req;
    d2 <= d1;
  end
  assign {clockFailure, breakInput, channelPin} = slow ? d2 : d1;
endmodule

// *** verif/mtcu_channel_unit_sva.sv ***
// Purpose: port checks of the channel unit
// Assumes: control writes use all byte lanes
// Notes:   interrupt enable shadowed from completed writes
`timescale 1ns/100ps
module mtcu_channel_unit_sva (
  input wire logic                          ref_clk,
  input wire logic                          rst,
  input wire logic [7:0]                    avs_address,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [31:0]                   avs_writedata,
  input wire logic [31:0]                   avs_readdata,
  input wire logic                          avs_waitrequest,
  input wire logic [mtcu_pkg::NUM_CH-1:0]   primaryOutput,
  input wire logic [mtcu_pkg::NUM_COMP-1:0] complementaryOutput,
  input wire logic                          breakIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic bie;
  wire  ctrlWr = avs_write && !avs_waitrequest && avs_address == 8'h00;
  always_ff @(posedge ref_clk) bie <= rst ? 1'b0 : (ctrlWr ? avs_writedata[10] : bie);
  sequence swBreak;
    ctrlWr && avs_writedata[11];
  endsequence
  sequence outOff;
    primaryOutput == '0 && complementaryOutput == '0;
  endsequence
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 8'h28
    |-> avs_readdata == '0) else $error("unmapped read not zero");
  no_overlap_a: assert property ((primaryOutput[2:0] & complementaryOutput) == '0)
    else $error("pair both high");
  sw_break_a: assert property (swBreak |-> ##[1:6] outOff)
    else $error("break left outputs on");
  irq_raise_a: assert property (swBreak ##0 avs_writedata[10] |-> ##[1:6] breakIrq)
    else $error("no break irq");
  irq_gate_a: assert property (breakIrq |-> bie)
    else $error("irq while disabled");
  reset_state_a: assert property ($past(rst) |-> avs_waitrequest && primaryOutput == '0)
    else $error("bad reset state");
endmodule
bind mtcu_channel_unit mtcu_channel_unit_sva mtcu_channel_unit_sva_inst (.ref_clk, .rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .primaryOutput, .complementaryOutput, .breakIrq);

// *** verif/mtcu_channel_unit_test.sv ***
// Purpose: self-checking bench of the channel unit
// Assumes: all byte lanes written
// Notes:   counter held for capture so captured values are known
`timescale 1ns/100ps
module mtcu_channel_unit_test;
  logic        ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, slow = 0, hold = 0;
  logic        countDown = 0, updateEvent1 = 0, avs_waitrequest, masterTriggerOutput, breakIrq;
  logic        breakInput, clockFailure;
  logic [7:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rnd = 32'h32AE, exp, q[$];
  logic [15:0] counterValue = '0;
  logic [5:0]  req = '0;
  logic [3:0]  channelPin, primaryOutput, primaryOutputEn_n;
  logic [2:0]  complementaryOutput, complementaryOutputEn_n;
  int          mismatches = 0, checked = 0, cyc = 0;
  mtcu_channel_unit mtcu_channel_unit_inst (.ref_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .counterValue, .countDown, .updateEvent1, .channelPin, .breakInput, .clockFailure,
    .primaryOutput, .primaryOutputEn_n, .complementaryOutput, .complementaryOutputEn_n,
    .masterTriggerOutput, .breakIrq);
  mtcu_pins_model mtcu_pins_model_inst (.ref_clk, .slow, .req, .channelPin, .breakInput,
    .clockFailure);
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 0;
    avs_read <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, '0);
  endtask
  task automatic settle;
    repeat (12) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) chk("readdata", q.pop_front(), avs_readdata);
    rnd <= xs(rnd);
    counterValue <= hold ? 16'h1234 : rnd[15:0];
    countDown <= rnd[16];
    updateEvent1 <= rnd[17];
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    rd(8'h00, '0);
    bus(1, 8'h2C, 32'hFFFF_FFFF);
    rd(8'h2C, '0);
    for (int i = 0; i < 4; i++) begin
      exp = rnd & 32'hFFFF;
      bus(1, 8'h18 + 8'(4 * i), exp);
      rd(8'h18 + 8'(4 * i), exp);
    end
    bus(1, 8'h00, 32'h205);
    bus(1, 8'h0C, 32'h500);
    bus(1, 8'h08, 32'h1D00);
    settle();
    chk("mto", 32'h1, 32'(masterTriggerOutput));
    chk("oen", 32'h76, 32'({primaryOutputEn_n, complementaryOutputEn_n}));
    chk("pair0", 32'h2, {primaryOutput[0], complementaryOutput[0]});
    bus(1, 8'h0C, 32'h400);
    bus(1, 8'h28, 32'h10);
    bus(1, 8'h08, 32'h1C00);
    settle();
    chk("mto", 32'h0, 32'(masterTriggerOutput));
    chk("pair0", 32'h0, {primaryOutput[0], complementaryOutput[0]});
    repeat (2) settle();
    chk("pair0", 32'h1, {primaryOutput[0], complementaryOutput[0]});
    bus(1, 8'h08, 32'h1D00);
    repeat (3) settle();
    bus(1, 8'h00, 32'hE05);
    settle();
    chk("pri", 32'h0, 32'(primaryOutput));
    chk("irq", 32'h1, 32'(breakIrq));
    hold <= 1;
    bus(1, 8'h04, 32'h1FF);
    bus(1, 8'h08, 32'h9);
    bus(1, 8'h0C, 32'h6);
    req[0] <= 1;
    settle();
    rd(8'h04, 32'h1);
    rd(8'h18, 32'h1234);
    req[0] <= 0;
    slow <= 1;
    settle();
    rd(8'h04, 32'h3);
    req[0] <= 1;
    settle();
    rd(8'h04, 32'h13);
    bus(1, 8'h04, 32'h1FF);
    bus(1, 8'h08, 32'hD00);
    bus(1, 8'h00, 32'h230);
    settle();
    chk("pri", 32'h1, 32'(primaryOutput));
    req[4] <= 1;
    settle();
    chk("pri", 32'h0, 32'(primaryOutput));
    rd(8'h04, 32'h100);
    summarize();
  end
endmodule
